// ==== common/sfbt_pkg.sv ====
`default_nettype none
package sfbt_pkg;

  // System clock rate in its two handy units
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CLK_KHZ = 25000;

  // Self-timed maximum durations, in the unit printed
  localparam int unsigned T_WP_US = 1;
  localparam int unsigned T_EDPD_US = 3;
  localparam int unsigned T_RDPD_US = 35;
  localparam int unsigned T_XFR_US = 200;
  localparam int unsigned T_COMP_US = 200;
  localparam int unsigned T_EP_MS = 35;
  localparam int unsigned T_P_MS = 4;
  localparam int unsigned T_PE_MS = 32;
  localparam int unsigned T_BE_MS = 75;
  localparam int unsigned T_SE_MS = 1300;

  // Longest times as whole cycles; each product is exact, nothing rounds
  localparam int unsigned WP_CYC = T_WP_US * CLK_MHZ;
  localparam int unsigned EDPD_CYC = T_EDPD_US * CLK_MHZ;
  localparam int unsigned RDPD_CYC = T_RDPD_US * CLK_MHZ;
  localparam int unsigned XFR_CYC = T_XFR_US * CLK_MHZ;
  localparam int unsigned COMP_CYC = T_COMP_US * CLK_MHZ;
  localparam int unsigned EP_CYC = T_EP_MS * CLK_KHZ;
  localparam int unsigned P_CYC = T_P_MS * CLK_KHZ;
  localparam int unsigned PE_CYC = T_PE_MS * CLK_KHZ;
  localparam int unsigned BE_CYC = T_BE_MS * CLK_KHZ;
  localparam int unsigned SE_CYC = T_SE_MS * CLK_KHZ;

  // Bits in one command or response byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Command byte codes
  localparam logic [7:0] OP_XFR = 8'h10;
  localparam logic [7:0] OP_COMP = 8'h11;
  localparam logic [7:0] OP_EP = 8'h20;
  localparam logic [7:0] OP_PROG = 8'h21;
  localparam logic [7:0] OP_PERASE = 8'h30;
  localparam logic [7:0] OP_BERASE = 8'h31;
  localparam logic [7:0] OP_SERASE = 8'h32;
  localparam logic [7:0] OP_DPD = 8'h40;
  localparam logic [7:0] OP_RESUME = 8'h41;

  // Response byte field positions
  localparam int unsigned ST_READY_BIT = 7;
  localparam int unsigned ST_PROT_BIT = 6;
  localparam int unsigned ST_MODE3_BIT = 5;

  typedef enum logic [1:0] {
    SFBT_READY = 2'b00,
    SFBT_BUSY = 2'b01,
    SFBT_DPD = 2'b10,
    SFBT_WAKE = 2'b11
  } sfbt_state_e;

endpackage
`default_nettype wire

// ==== logic/sfbt_device.sv ====
// Functional notes
// - Input bits sampled on rising clock, output bits shifted on falling clock.
// - Clock level when select falls picks mode 0 or mode 3.
// - Output bit is valid during the clock low phase.
// - Output may also settle after low phase; valid up to interface maximum.
// - Deep power-down reached within 3 us after select rises.
// - Resume reaches standby within 35 us; host waits meanwhile.
// - Write-protect low enables protection, high disables it, within 1 us.
// - Page to buffer transfer self-timed, at most 200 us, busy meanwhile.
// - Page to buffer compare self-timed, at most 200 us, busy meanwhile.
// - Page erase and program self-timed, at most 35 ms.
// - Page program self-timed, at most 4 ms.
// - Page erase self-timed, at most 32 ms.
// - Block erase self-timed, at most 75 ms.
// - Sector erase self-timed, at most 1.3 s.
// - Response byte starts on falling edge after last command bit; none is driven in deep power-down.
`timescale 1ns/1ns
`default_nettype none

module sfbt_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Signals from outside the domain
  output logic [WIDTH-1:0] sync_out // Two flops later
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // sfbt_sync

module sfbt_device
  import sfbt_pkg::*;
#(
  parameter int unsigned XFR_CYCLES = XFR_CYC,
  parameter int unsigned COMP_CYCLES = COMP_CYC,
  parameter int unsigned EP_CYCLES = EP_CYC,
  parameter int unsigned P_CYCLES = P_CYC,
  parameter int unsigned PE_CYCLES = PE_CYC,
  parameter int unsigned BE_CYCLES = BE_CYC,
  parameter int unsigned SE_CYCLES = SE_CYC
) (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in pin
  input wire logic wp_n, // Write-protect pin, active low
  input wire logic dev_reset_n, // Device reset pin, active low
  output logic so, // Serial data out
  output logic so_oe, // Output enable for serial data out
  output logic ready, // High when no self-timed work is running and not in deep power-down
  output logic protect_on, // Hardware sector protection active
  output logic deep_pd, // Device in deep power-down
  output logic mode3 // Clock idled high at last selection
);

  logic [4:0] pins_sync;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic wp_s;
  logic rstp_s;
  sfbt_sync #(.WIDTH(5)) u_sync (
    .clk(sys_clk),
    .rst_n(reset_n),
    .async_in({dev_reset_n, wp_n, si, sck, cs_n}),
    .sync_out(pins_sync)
  );
  assign cs_s = pins_sync[0];
  assign sck_s = pins_sync[1];
  assign si_s = pins_sync[2];
  assign wp_s = pins_sync[3];
  assign rstp_s = pins_sync[4];

  // Edge detection on the synchronised pins
  logic sck_prev_q;
  logic cs_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_prev_q <= 1'b1; // Same level as the synchroniser after reset
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;

  // Link state
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] sr_q, sr_d;
  logic armed_q, armed_d;
  logic out_act_q, out_act_d;
  logic mode3_q, mode3_d;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;
  logic [7:0] status;
  sfbt_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic protect_q, protect_d, ready_q, ready_d, dpd_q, dpd_d;
  logic cmd_done;

  always_comb
  begin
    status = 8'h00;
    status[ST_READY_BIT] = (st_q == SFBT_READY);
    status[ST_PROT_BIT] = protect_q;
    status[ST_MODE3_BIT] = mode3_q;
  end

  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    cmd_d = cmd_q;
    sr_d = sr_q;
    armed_d = armed_q;
    out_act_d = out_act_q;
    mode3_d = mode3_q;
    so_d = so_q;
    so_oe_d = so_oe_q;
    if (!rstp_s)
    begin
      // Select is expected high here, so the link simply idles
      bit_cnt_d = 4'h0;
      armed_d = 1'b0;
      out_act_d = 1'b0;
      so_oe_d = 1'b0;
    end
    else if (cs_fall)
    begin
      mode3_d = sck_s;
      bit_cnt_d = 4'h0;
      armed_d = 1'b0;
      out_act_d = 1'b0;
    end
    else if (cs_s)
    begin
      out_act_d = 1'b0;
      so_oe_d = 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        // In mode 3 the first edge is a fall; it must not shift data
        armed_d = 1'b1;
        if (bit_cnt_q < BYTE_BITS)
        begin
          cmd_d = {cmd_q[6:0], si_s};
          bit_cnt_d = bit_cnt_q + 4'h1;
        end
      end
      if (sck_fall && armed_q && bit_cnt_q == BYTE_BITS && st_q != SFBT_DPD)
      begin
        // Bit leaves on the fall so it is valid in the low phase
        out_act_d = 1'b1;
        so_oe_d = 1'b1;
        if (!out_act_q)
        begin
          so_d = status[7];
          sr_d = {status[6:0], status[7]};
        end
        else
        begin
          // Status byte repeats for as long as the host keeps clocking
          so_d = sr_q[7];
          sr_d = {sr_q[6:0], sr_q[7]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_q <= 4'h0;
      cmd_q <= 8'h00;
      sr_q <= 8'h00;
      armed_q <= 1'b0;
      out_act_q <= 1'b0;
      mode3_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      cmd_q <= cmd_d;
      sr_q <= sr_d;
      armed_q <= armed_d;
      out_act_q <= out_act_d;
      mode3_q <= mode3_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  // A command counts when at least one whole byte came before deselect; extra bits are ignored
  assign cmd_done = cs_rise && bit_cnt_q == BYTE_BITS;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    // Pin sync and the protect register add three cycles, far inside the allowed window
    protect_d = ~wp_s;
    if (!rstp_s)
    begin
      // Device reset aborts any self-timed work
      st_d = SFBT_READY;
      cnt_d = 32'h0;
    end
    else
    begin
      case (st_q)
        SFBT_READY:
        begin
          if (cmd_done)
          begin
            st_d = SFBT_BUSY;
            case (cmd_q)
              OP_XFR: cnt_d = XFR_CYCLES - 1;
              OP_COMP: cnt_d = COMP_CYCLES - 1;
              OP_EP: cnt_d = EP_CYCLES - 1;
              OP_PROG: cnt_d = P_CYCLES - 1;
              OP_PERASE: cnt_d = PE_CYCLES - 1;
              OP_BERASE: cnt_d = BE_CYCLES - 1;
              OP_SERASE: cnt_d = SE_CYCLES - 1;
              OP_DPD: st_d = SFBT_DPD;
              default: st_d = SFBT_READY;
            endcase
          end
        end
        SFBT_BUSY:
        begin
          // New array commands are ignored until the timer ends
          if (cnt_q == 32'h0)
          begin
            st_d = SFBT_READY;
          end
          else
          begin
            cnt_d = cnt_q - 32'h1;
          end
        end
        SFBT_DPD:
        begin
          // Only the resume command is heard in deep power-down
          if (cmd_done && cmd_q == OP_RESUME)
          begin
            st_d = SFBT_WAKE;
            cnt_d = RDPD_CYC - 1;
          end
        end
        SFBT_WAKE:
        begin
          if (cnt_q == 32'h0)
          begin
            st_d = SFBT_READY;
          end
          else
          begin
            cnt_d = cnt_q - 32'h1;
          end
        end
        default:
        begin
          st_d = SFBT_READY;
        end
      endcase
    end
    ready_d = (st_d == SFBT_READY);
    dpd_d = (st_d == SFBT_DPD);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= SFBT_READY;
      cnt_q <= 32'h0;
      protect_q <= 1'b0;
      ready_q <= 1'b1;
      dpd_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      protect_q <= protect_d;
      ready_q <= ready_d;
      dpd_q <= dpd_d;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign ready = ready_q;
  assign protect_on = protect_q;
  assign deep_pd = dpd_q;
  assign mode3 = mode3_q;

endmodule // sfbt_device

`default_nettype wire

// ==== test/sfbt_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module sfbt_props
  import sfbt_pkg::*;
#(
  parameter int unsigned XFR_CYCLES = 20, COMP_CYCLES = 20, EP_CYCLES = 20, P_CYCLES = 20,
  parameter int unsigned PE_CYCLES = 20, BE_CYCLES = 20, SE_CYCLES = 20
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic cs_n, // Select
  input wire logic sck, // Serial clock
  input wire logic si, // Data in
  input wire logic wp_n, // Write protect
  input wire logic dev_reset_n, // Device reset
  input wire logic so, // Data out
  input wire logic so_oe, // Data out enable
  input wire logic ready, // Idle
  input wire logic protect_on, // Protection
  input wire logic deep_pd, // Power-down
  input wire logic mode3 // Clock idled high
);
  // Sum rather than max: a loose ceiling is enough to catch a stuck timer
  localparam longint LIM = longint'(XFR_CYCLES) + COMP_CYCLES + EP_CYCLES + P_CYCLES
    + PE_CYCLES + BE_CYCLES + SE_CYCLES + RDPD_CYC + 8;
  logic [31:0] busy_q;
  logic [31:0] busy_d;
  always_comb busy_d = (ready || deep_pd) ? 32'h0 : busy_q + 32'h1;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) busy_q <= 32'h0;
    else busy_q <= busy_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_wp_enable: assert property ($fell(wp_n) |-> ##[1:25] protect_on)
    else $error("protection late after wp_n low");
  chk_wp_disable: assert property ($rose(wp_n) |-> ##[1:25] !protect_on)
    else $error("protection late after wp_n high");
  chk_mode_latch: assert property ($fell(cs_n) |-> ##6 mode3 == $past(sck, 6))
    else $error("mode3 not the clock level at select");
  chk_so_low_phase: assert property ($changed(so) && so_oe && $past(so_oe) |-> !sck)
    else $error("so moved outside clock low phase");
  chk_oe_idle: assert property (cs_n [*5] |-> !so_oe)
    else $error("so driven while deselected");
  chk_dpd_quiet: assert property (deep_pd |-> !so_oe && !ready)
    else $error("activity in power-down");
  chk_dpd_entry: assert property ($rose(deep_pd) |-> cs_n)
    else $error("power-down entered while selected");
  chk_wake_busy: assert property ($fell(deep_pd) |-> !ready [*8])
    else $error("ready too soon after resume");
  chk_busy_start: assert property ($fell(ready) |-> cs_n)
    else $error("busy began mid-frame");
  chk_busy_bound: assert property (busy_q <= LIM)
    else $error("busy past its limit");
  chk_dev_reset: assert property (!dev_reset_n [*4] |-> ready && !deep_pd)
    else $error("device reset did not idle");
  cov_dpd: cover property ($rose(deep_pd));
  cov_prot: cover property ($rose(protect_on));
  cov_mode3: cover property ($rose(mode3));
  cov_busy: cover property ($fell(ready) ##1 !deep_pd);
endmodule // sfbt_props
bind sfbt_device sfbt_props #(.XFR_CYCLES(XFR_CYCLES), .COMP_CYCLES(COMP_CYCLES),
  .EP_CYCLES(EP_CYCLES), .P_CYCLES(P_CYCLES), .PE_CYCLES(PE_CYCLES),
  .BE_CYCLES(BE_CYCLES), .SE_CYCLES(SE_CYCLES)) sfbt_props_i (.sys_clk(sys_clk),
  .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
  .dev_reset_n(dev_reset_n), .so(so), .so_oe(so_oe), .ready(ready),
  .protect_on(protect_on), .deep_pd(deep_pd), .mode3(mode3));
`default_nettype wire

// ==== test/sfbt_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module sfbt_host (
  input wire logic sys_clk, // Bench clock
  input wire logic so, // Data from device
  output var logic cs_n = 1'b1, // Select, active low
  output var logic sck = 1'b0, // Clock, still between frames
  output var logic si = 1'b0 // Data to device
);
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // 8 sys_clk per bit gives 320 ns, far below every clock ceiling
  task automatic xfer(input logic [7:0] cmd, input logic m3, output logic [7:0] rsp);
    rsp = 8'h00;
    @(posedge sys_clk) sck <= m3;
    si <= cmd[7];
    hold(8);
    cs_n <= 1'b0;
    hold(8);
    if (m3)
    begin
      sck <= 1'b0;
      hold(4);
    end
    for (int i = 0; i < 16; i++)
    begin
      hold(4);
      sck <= 1'b1;
      hold(1);
      si <= (i < 7) ? cmd[6-i] : ~si;
      hold(3);
      if (i > 7) rsp[15-i] = so;
      sck <= 1'b0;
    end
    hold(4);
    sck <= m3;
    hold(4);
    cs_n <= 1'b1;
    si <= ~si;
    hold(8);
  endtask
endmodule // sfbt_host
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sfbt_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp_n = 1'b1;
  logic dev_reset_n = 1'b0;
  logic cs_n, sck, si, so, so_oe, ready, protect_on, deep_pd, mode3;
  logic [7:0] rsp;
  int err_total = 0;
  int n_checks = 0;
  // Length of the last busy run; power-down itself is not counted
  int low_cnt = 0;
  int low_len = 0;
  always #20 sys_clk = ~sys_clk;
  // Transfer and compare keep their real lengths; the long ones are shortened
  sfbt_device #(.EP_CYCLES(28), .P_CYCLES(32), .PE_CYCLES(36), .BE_CYCLES(40),
    .SE_CYCLES(44)) sfbt_device_i (.sys_clk(sys_clk),
    .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .dev_reset_n(dev_reset_n), .so(so), .so_oe(so_oe), .ready(ready),
    .protect_on(protect_on), .deep_pd(deep_pd), .mode3(mode3));
  sfbt_host sfbt_host_i (.sys_clk(sys_clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge sys_clk)
  begin
    if (!ready && !deep_pd)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      low_len <= low_cnt;
      low_cnt <= 0;
    end
  end
  // Busy starts after deselect but before xfer returns, so the monitor above measures it whole
  task automatic busy_len(output int n);
    n = 0;
    while (!ready && n < 6000)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    n = low_len;
  endtask
  task automatic t_status;
    for (int m = 0; m < 2; m++)
    begin
      sfbt_host_i.xfer(8'h00, m[0], rsp);
      check(rsp, {2'b10, m[0], 5'h00});
      check(mode3, m[0]);
    end
    $display("t_status done");
  endtask
  task automatic t_timed;
    logic [7:0] ops [7] = '{OP_XFR, OP_COMP, OP_EP, OP_PROG, OP_PERASE, OP_BERASE, OP_SERASE};
    int n;
    for (int k = 0; k < 7; k++)
    begin
      sfbt_host_i.xfer(ops[k], k[0], rsp);
      check(ready, 1'b0);
      if (k == 0)
      begin
        sfbt_host_i.xfer(OP_COMP, 1'b0, rsp);
        check(rsp, 8'h00);
      end
      busy_len(n);
      check(n, (k == 0) ? XFR_CYC : (k == 1) ? COMP_CYC : 20 + 4 * k);
    end
    $display("t_timed done");
  endtask
  task automatic t_dpd;
    int n;
    sfbt_host_i.xfer(OP_DPD, 1'b0, rsp);
    repeat (EDPD_CYC) @(negedge sys_clk);
    check(deep_pd, 1'b1);
    sfbt_host_i.xfer(OP_XFR, 1'b0, rsp);
    check(deep_pd, 1'b1);
    sfbt_host_i.xfer(OP_RESUME, 1'b1, rsp);
    busy_len(n);
    check(n, RDPD_CYC);
    check(deep_pd, 1'b0);
    $display("t_dpd done");
  endtask
  task automatic t_wp;
    @(posedge sys_clk) wp_n <= 1'b0;
    repeat (WP_CYC) @(negedge sys_clk);
    check(protect_on, 1'b1);
    sfbt_host_i.xfer(8'h00, 1'b1, rsp);
    check(rsp, 8'he0);
    @(posedge sys_clk) wp_n <= 1'b1;
    repeat (WP_CYC) @(negedge sys_clk);
    check(protect_on, 1'b0);
    $display("t_wp done");
  endtask
  task automatic t_abort;
    sfbt_host_i.xfer(OP_SERASE, 1'b0, rsp);
    repeat (10) @(posedge sys_clk);
    dev_reset_n <= 1'b0;
    repeat (6) @(negedge sys_clk);
    check(ready, 1'b1);
    @(posedge sys_clk) dev_reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    $display("t_abort done");
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    dev_reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_status();
    t_timed();
    t_dpd();
    t_wp();
    t_abort();
    stop_test();
  end
  // Whole run needs under 14000 cycles; a hang trips well after that
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
